/* hdl/gu_uart.sv */
// serial port register frame: fifos, 8n1 line engines, wishbone slave
// assumes a classic wishbone master and an asynchronous rx pin
`timescale 1ns/1ps
`include "gu_params.svh"

module gu_uart
  import gu_pkg::*;
#(
  parameter int DEPTH = `GU_FIFO_DEPTH,
  parameter int BIT_CYC = `GU_BIT_CYC
)(
  input wire logic core_clk, // 40 mhz clock
  input wire logic arst_n, // async reset, active low
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [11:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte enables
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  input wire logic rxd, // serial input pin
  output logic txd, // serial output pin
  output logic port_irq_out // level interrupt
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(BIT_CYC + 1);
  localparam int HALF = DEPTH / 2;

  // elaboration checks; the start-bit assertion needs eight low samples
  if (DEPTH < 32 || (1 << AW) != DEPTH)
  begin
    $error("depth must be a power of two of at least 32");
  end
  if (BIT_CYC < 8)
  begin
    $error("bit period too short");
  end

  logic ack_ff;
  logic [31:0] rdata_ff;
  logic req, wr, rd;
  logic hit_data, hit_rsr, hit_flags, hit_mask, hit_ris, hit_mis, hit_icr;
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;
  assign hit_data = {wb_adr_i[11:2], 2'b00} == `GU_OFF_DATA;
  assign hit_rsr = {wb_adr_i[11:2], 2'b00} == `GU_OFF_RSR;
  assign hit_flags = {wb_adr_i[11:2], 2'b00} == `GU_OFF_FLAGS;
  assign hit_mask = {wb_adr_i[11:2], 2'b00} == `GU_OFF_MASK;
  assign hit_ris = {wb_adr_i[11:2], 2'b00} == `GU_OFF_RIS;
  assign hit_mis = {wb_adr_i[11:2], 2'b00} == `GU_OFF_MIS;
  assign hit_icr = {wb_adr_i[11:2], 2'b00} == `GU_OFF_ICR;

  // transmit fifo: 8-bit entries
  logic [7:0] tx_mem [DEPTH];
  logic [AW-1:0] tx_wp_ff, tx_rp_ff;
  logic [AW:0] tx_cnt_ff;
  logic tx_push, tx_pop, tx_full, tx_empty;
  assign tx_full = tx_cnt_ff == (AW+1)'(DEPTH);
  assign tx_empty = tx_cnt_ff == '0;
  // a write into a full fifo is dropped, as software polls the full flag
  assign tx_push = wr & hit_data & wb_sel_i[0] & ~tx_full;

  always_ff @(posedge core_clk)
  begin
    if (tx_push)
      tx_mem[tx_wp_ff] <= wb_dat_i[7:0];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_wp_ff <= '0;
      tx_rp_ff <= '0;
      tx_cnt_ff <= '0;
    end
    else
    begin
      if (tx_push)
        tx_wp_ff <= tx_wp_ff + 1'b1;
      if (tx_pop)
        tx_rp_ff <= tx_rp_ff + 1'b1;
      if (tx_push && !tx_pop)
        tx_cnt_ff <= tx_cnt_ff + 1'b1;
      else if (tx_pop && !tx_push)
        tx_cnt_ff <= tx_cnt_ff - 1'b1;
    end
  end

  // receive fifo: {overrun, break, parity, framing, data}
  logic [11:0] rx_mem [DEPTH];
  logic [AW-1:0] rx_wp_ff, rx_rp_ff;
  logic [AW:0] rx_cnt_ff;
  logic rx_push, rx_pop, rx_full, rx_empty, rx_done;
  logic [11:0] rx_entry, rx_head;
  logic ovr_pend_ff;
  assign rx_full = rx_cnt_ff == (AW+1)'(DEPTH);
  assign rx_empty = rx_cnt_ff == '0;
  assign rx_push = rx_done & ~rx_full;
  assign rx_pop = rd & hit_data & ~rx_empty;
  assign rx_head = rx_mem[rx_rp_ff];

  always_ff @(posedge core_clk)
  begin
    if (rx_push)
      rx_mem[rx_wp_ff] <= rx_entry;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_wp_ff <= '0;
      rx_rp_ff <= '0;
      rx_cnt_ff <= '0;
    end
    else
    begin
      if (rx_push)
        rx_wp_ff <= rx_wp_ff + 1'b1;
      if (rx_pop)
        rx_rp_ff <= rx_rp_ff + 1'b1;
      if (rx_push && !rx_pop)
        rx_cnt_ff <= rx_cnt_ff + 1'b1;
      else if (rx_pop && !rx_push)
        rx_cnt_ff <= rx_cnt_ff - 1'b1;
    end
  end

  // overrun is tagged onto the next character that does get stored
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ovr_pend_ff <= 1'b0;
    else if (rx_done && rx_full)
      ovr_pend_ff <= 1'b1;
    else if (rx_push)
      ovr_pend_ff <= 1'b0;
  end

  // rx pin: three flops, a change counts once stages two and three agree
  logic rx_m1_ff, rx_m2_ff, rx_m3_ff, rx_s_ff;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_m1_ff <= 1'b1;
      rx_m2_ff <= 1'b1;
      rx_m3_ff <= 1'b1;
      rx_s_ff <= 1'b1;
    end
    else
    begin
      rx_m1_ff <= rxd;
      rx_m2_ff <= rx_m1_ff;
      rx_m3_ff <= rx_m2_ff;
      if (rx_m2_ff == rx_m3_ff)
        rx_s_ff <= rx_m3_ff;
    end
  end

  // receiver: 8 data bits, no parity, one stop bit
  gu_bit_st_t rx_st_ff;
  logic [CW-1:0] rx_tmr_ff;
  logic [2:0] rx_bit_ff;
  logic [7:0] rx_sh_ff;
  logic rx_fe, rx_be;
  assign rx_fe = ~rx_s_ff;
  assign rx_be = ~rx_s_ff & (rx_sh_ff == 8'h00);
  assign rx_done = (rx_st_ff == GU_STOP) && (rx_tmr_ff == '0);
  assign rx_entry = {ovr_pend_ff, rx_be, 1'b0, rx_fe, rx_sh_ff};

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_st_ff <= GU_IDLE;
      rx_tmr_ff <= '0;
      rx_bit_ff <= '0;
      rx_sh_ff <= '0;
    end
    else
    begin
      if (rx_tmr_ff != '0)
        rx_tmr_ff <= rx_tmr_ff - 1'b1;
      case (rx_st_ff)
        GU_IDLE:
          if (!rx_s_ff)
          begin
            rx_st_ff <= GU_START;
            rx_tmr_ff <= CW'(BIT_CYC / 2);
          end
        GU_START:
          if (rx_tmr_ff == '0)
          begin
            // a glitch shorter than half a bit is not a start bit
            rx_st_ff <= rx_s_ff ? GU_IDLE : GU_DATA;
            rx_tmr_ff <= CW'(BIT_CYC - 1);
            rx_bit_ff <= '0;
          end
        GU_DATA:
          if (rx_tmr_ff == '0)
          begin
            rx_sh_ff <= {rx_s_ff, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 1'b1;
            rx_tmr_ff <= CW'(BIT_CYC - 1);
            if (rx_bit_ff == 3'(`GU_WORD_BITS - 1))
              rx_st_ff <= GU_STOP;
          end
        GU_STOP:
          if (rx_tmr_ff == '0)
            rx_st_ff <= GU_IDLE;
        default:
          rx_st_ff <= GU_IDLE;
      endcase
    end
  end

  // transmitter: start, 8 data bits lsb first, stop
  gu_bit_st_t tx_st_ff;
  logic [CW-1:0] tx_tmr_ff;
  logic [2:0] tx_bit_ff;
  logic [7:0] tx_sh_ff;
  logic txd_ff;
  assign tx_pop = (tx_st_ff == GU_IDLE) && !tx_empty;
  assign txd = txd_ff;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_st_ff <= GU_IDLE;
      tx_tmr_ff <= '0;
      tx_bit_ff <= '0;
      tx_sh_ff <= '0;
      txd_ff <= 1'b1;
    end
    else
    begin
      if (tx_tmr_ff != '0)
        tx_tmr_ff <= tx_tmr_ff - 1'b1;
      case (tx_st_ff)
        GU_IDLE:
          if (tx_pop)
          begin
            tx_st_ff <= GU_START;
            tx_sh_ff <= tx_mem[tx_rp_ff];
            tx_tmr_ff <= CW'(BIT_CYC - 1);
            txd_ff <= 1'b0;
          end
        GU_START:
          if (tx_tmr_ff == '0)
          begin
            tx_st_ff <= GU_DATA;
            tx_bit_ff <= '0;
            tx_tmr_ff <= CW'(BIT_CYC - 1);
            txd_ff <= tx_sh_ff[0];
          end
        GU_DATA:
          if (tx_tmr_ff == '0)
          begin
            tx_tmr_ff <= CW'(BIT_CYC - 1);
            tx_bit_ff <= tx_bit_ff + 1'b1;
            tx_sh_ff <= {1'b0, tx_sh_ff[7:1]};
            if (tx_bit_ff == 3'(`GU_WORD_BITS - 1))
            begin
              tx_st_ff <= GU_STOP;
              txd_ff <= 1'b1;
            end
            else
              txd_ff <= tx_sh_ff[1];
          end
        GU_STOP:
          if (tx_tmr_ff == '0)
            tx_st_ff <= GU_IDLE;
        default:
          tx_st_ff <= GU_IDLE;
      endcase
    end
  end

  // receive timeout: counts bit periods of silence with data waiting
  logic [CW-1:0] rt_tmr_ff;
  logic [5:0] rt_bits_ff;
  logic rt_evt;
  assign rt_evt = (rt_tmr_ff == '0) && (rt_bits_ff == 6'(`GU_RT_BITS - 1));
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rt_tmr_ff <= CW'(BIT_CYC - 1);
      rt_bits_ff <= '0;
    end
    else if (rx_empty || rx_push || rx_pop || rx_st_ff != GU_IDLE)
    begin
      rt_tmr_ff <= CW'(BIT_CYC - 1);
      rt_bits_ff <= '0;
    end
    else if (rt_tmr_ff != '0)
      rt_tmr_ff <= rt_tmr_ff - 1'b1;
    else if (rt_bits_ff != 6'(`GU_RT_BITS))
    begin
      rt_tmr_ff <= CW'(BIT_CYC - 1);
      rt_bits_ff <= rt_bits_ff + 1'b1;
    end
  end

  // receive error status: set from each popped character, set wins
  logic [3:0] rsr_ff;
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      rsr_ff <= '0;
    else if (rx_pop)
      rsr_ff <= rsr_ff | rx_head[11:8];
    else if (wr && hit_rsr)
      rsr_ff <= '0;
  end

  // interrupts: events, sticky raw status, mask and clear
  logic [6:0] raw_ff, mask_ff, irq_set, irq_clr, mis;
  always_comb
  begin
    irq_set = '0;
    irq_set[`GU_IRQ_RX] = rx_push && !rx_pop &&
      rx_cnt_ff == (AW+1)'(HALF - 1);
    irq_set[`GU_IRQ_TX] = tx_pop && !tx_push &&
      tx_cnt_ff == (AW+1)'(HALF + 1);
    irq_set[`GU_IRQ_RT] = rt_evt;
    irq_set[`GU_IRQ_FE] = rx_push && rx_fe;
    irq_set[`GU_IRQ_BE] = rx_push && rx_be;
    irq_set[`GU_IRQ_OE] = rx_done && rx_full;
  end

  // clear lanes follow the byte enables that cover bits 10:4
  assign irq_clr = (wr && hit_icr) ?
    ({{3{wb_sel_i[1]}}, {4{wb_sel_i[0]}}} & wb_dat_i[10:4]) : '0;
  assign mis = raw_ff & ~mask_ff;
  assign port_irq_out = |mis;

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      raw_ff <= '0;
    else
      raw_ff <= (raw_ff & ~irq_clr) | irq_set;
  end

  // all sources masked after reset so no interrupt fires before setup
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_ff <= `GU_MASK_RST;
    else if (wr && hit_mask)
    begin
      if (wb_sel_i[0])
        mask_ff[3:0] <= wb_dat_i[7:4];
      if (wb_sel_i[1])
        mask_ff[6:4] <= wb_dat_i[10:8];
    end
  end

  // register bus: every access answered one cycle after it is taken
  logic [31:0] nxt_rdata;
  logic [7:0] flags;
  always_comb
  begin
    flags = '0;
    flags[`GU_FLG_BUSY] = (tx_st_ff != GU_IDLE) || !tx_empty;
    flags[`GU_FLG_RXFE] = rx_empty;
    flags[`GU_FLG_TXFF] = tx_full;
    flags[`GU_FLG_RXFF] = rx_full;
    flags[`GU_FLG_TXFE] = tx_empty;
    nxt_rdata = '0;
    if (hit_data)
      nxt_rdata[11:0] = rx_empty ? 12'h000 : rx_head;
    else if (hit_rsr)
      nxt_rdata[3:0] = rsr_ff;
    else if (hit_flags)
      nxt_rdata[7:0] = flags;
    else if (hit_mask)
      nxt_rdata[10:4] = mask_ff;
    else if (hit_ris)
      nxt_rdata[10:4] = raw_ff;
    else if (hit_mis)
      nxt_rdata[10:4] = mis;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= '0;
    end
    else
    begin
      ack_ff <= req;
      if (rd)
        rdata_ff <= nxt_rdata;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_ack_once;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack not a single cycle after request");

  property p_tx_push;
    (tx_push && !tx_pop) |=> tx_cnt_ff == $past(tx_cnt_ff) + 1'b1;
  endproperty
  a_tx_push: assert property (p_tx_push)
    else $error("tx fifo count did not grow on write");

  property p_rx_read;
    rx_pop |=> wb_dat_o[11:0] == $past(rx_head) && wb_dat_o[31:12] == '0;
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("data port read returned wrong entry");

  property p_rsr_clear;
    (wr && hit_rsr && !rx_pop) |=> rsr_ff == '0;
  endproperty
  a_rsr_clear: assert property (p_rsr_clear)
    else $error("error status not cleared by write");

  property p_flag_read;
    (rd && hit_flags) |=> wb_dat_o[`GU_FLG_RXFE] == $past(rx_empty) &&
      wb_dat_o[`GU_FLG_TXFF] == $past(tx_full);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag register mismatch");

  property p_mis_read;
    (rd && hit_mis) |=> wb_dat_o[10:4] == ($past(raw_ff) & ~$past(mask_ff));
  endproperty
  a_mis_read: assert property (p_mis_read)
    else $error("masked status mismatch");

  property p_mask_wr;
    (wr && hit_mask && wb_sel_i[1:0] == 2'b11) |=>
      mask_ff == $past(wb_dat_i[10:4]);
  endproperty
  a_mask_wr: assert property (p_mask_wr)
    else $error("mask write not stored");

  property p_icr;
    (irq_clr != '0 && irq_set == '0) |=> (raw_ff & $past(irq_clr)) == '0;
  endproperty
  a_icr: assert property (p_icr)
    else $error("interrupt clear did not clear raw bit");

  property p_irq_seen;
    (rd && hit_mis && port_irq_out) |=> wb_dat_o[10:4] != '0;
  endproperty
  a_irq_seen: assert property (p_irq_seen)
    else $error("interrupt high with no masked status");

  property p_tx_frame;
    $rose(tx_st_ff == GU_START) |-> !txd_ff [*8];
  endproperty
  a_tx_frame: assert property (p_tx_frame)
    else $error("start bit not held low");

  c_rx_char: cover property (rx_push);
  c_irq: cover property ($rose(port_irq_out));
  c_tx_full: cover property (tx_full);
endmodule

/* hdl/gu_params.svh */
// register offsets, field positions, reset values and timing counts
// assumes byte addresses on a 12-bit register window
`ifndef GU_PARAMS_SVH
`define GU_PARAMS_SVH
`define GU_OFF_DATA 12'h000
`define GU_OFF_RSR 12'h004
`define GU_OFF_FLAGS 12'h018
`define GU_OFF_MASK 12'h038
`define GU_OFF_RIS 12'h03c
`define GU_OFF_MIS 12'h040
`define GU_OFF_ICR 12'h044
`define GU_ERR_LSB 8
`define GU_IRQ_LSB 4
`define GU_FLG_BUSY 3
`define GU_FLG_RXFE 4
`define GU_FLG_TXFF 5
`define GU_FLG_RXFF 6
`define GU_FLG_TXFE 7
`define GU_IRQ_RX 0
`define GU_IRQ_TX 1
`define GU_IRQ_RT 2
`define GU_IRQ_FE 3
`define GU_IRQ_PE 4
`define GU_IRQ_BE 5
`define GU_IRQ_OE 6
`define GU_MASK_RST 7'h7f
`define GU_WORD_BITS 8
`define GU_FIFO_DEPTH 32
`define GU_BIT_NS 8680
`define GU_CLK_NS 25
`define GU_BIT_CYC ((`GU_BIT_NS) / (`GU_CLK_NS))
`define GU_RT_BITS 32
`endif

/* hdl/gu_pkg.sv */
// types shared by the serial port frame
// no assumptions beyond a single clock domain
package gu_pkg;
  typedef enum logic [1:0] {GU_IDLE, GU_START, GU_DATA, GU_STOP} gu_bit_st_t;
endpackage

/* dv/tb.sv */
// self-checking bench for the serial port register frame
// assumes gu_uart with a short bit period; the bench plays the remote line
`timescale 1ns/1ps
`include "gu_params.svh"

module tb;
  localparam int BC = 8;
  localparam int DP = `GU_FIFO_DEPTH;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic rxd = 1'b1;
  logic txd;
  logic irq;
  logic [31:0] q;
  logic [7:0] tx_byte;
  int n_mismatch = 0;
  int check_count = 0;
  int tick = 0;

  gu_uart #(.DEPTH(DP), .BIT_CYC(BC)) dut (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(dat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .rxd(rxd),
    .txd(txd),
    .port_irq_out(irq)
  );

  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // the whole run needs well under half of this
  always @(posedge core_clk)
  begin
    tick <= tick + 1;
    if (tick == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one classic cycle; held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [11:0] a,
      input logic [3:0] s, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    // only the bench timeout ends this wait
    do
    begin
      @(posedge core_clk);
    end
    while (ack !== 1'b1);
    q = rdat;
    chk({31'h0, ack}, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
      input logic [31:0] msk);
    wb(1'b0, a, 4'hf, 32'h0);
    chk(q & msk, exp);
  endtask

  task automatic wr(input logic [11:0] a, input logic [3:0] s,
      input logic [31:0] d);
    wb(1'b1, a, s, d);
  endtask

  // 8n1 frame, lsb first; stop level chosen to provoke a frame error
  task automatic send_rx(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rxd <= f[i];
      repeat (BC) @(posedge core_clk);
    end
    rxd <= 1'b1;
    repeat (BC) @(posedge core_clk);
  endtask

  task automatic grab_tx(output logic [7:0] b);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 400)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (BC / 2) @(posedge core_clk);
    chk({31'h0, txd}, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BC) @(posedge core_clk);
      b[i] = txd;
    end
    repeat (BC) @(posedge core_clk);
    chk({31'h0, txd}, 32'h1);
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rd(`GU_OFF_MASK, 32'h7f0, 32'hffff_fff0);
    rd(`GU_OFF_FLAGS, 32'h90, ALL);
    rd(`GU_OFF_RIS, 32'h0, ALL);
    rd(`GU_OFF_MIS, 32'h0, ALL);
    rd(12'h100, 32'h0, ALL);
    // byte write on lane 0 goes out on the line
    fork
      wr(`GU_OFF_DATA, 4'h1, 32'h0000_00a5);
      grab_tx(tx_byte);
    join
    chk({24'h0, tx_byte}, 32'ha5);
    send_rx(8'h3c, 1'b1);
    rd(`GU_OFF_DATA, 32'h03c, ALL);
    rd(`GU_OFF_FLAGS, 32'h10, 32'h50);
    // frame error path: data flag, status, clear, raw event, irq
    send_rx(8'h5a, 1'b0);
    rd(`GU_OFF_DATA, 32'h15a, ALL);
    rd(`GU_OFF_RSR, 32'h1, ALL);
    wr(`GU_OFF_RSR, 4'h1, 32'h0);
    rd(`GU_OFF_RSR, 32'h0, ALL);
    rd(`GU_OFF_RIS, 32'h80, 32'h80);
    rd(`GU_OFF_MIS, 32'h0, ALL);
    chk({31'h0, irq}, 32'h0);
    wr(`GU_OFF_MASK, 4'h3, 32'h0000_077f);
    rd(`GU_OFF_MASK, 32'h770, 32'h7f0);
    rd(`GU_OFF_MIS, 32'h80, ALL);
    chk({31'h0, irq}, 32'h1);
    wr(`GU_OFF_ICR, 4'h3, 32'h0000_0080);
    rd(`GU_OFF_RIS, 32'h0, 32'h80);
    chk({31'h0, irq}, 32'h0);
    wr(`GU_OFF_MASK, 4'h3, 32'h0000_07ff);
    // one character more than the receive fifo holds
    for (int i = 0; i <= DP; i++)
      send_rx(i[7:0], 1'b1);
    rd(`GU_OFF_FLAGS, 32'h40, 32'h50);
    rd(`GU_OFF_RIS, 32'h10, 32'h10);
    for (int i = 0; i < DP; i++)
      rd(`GU_OFF_DATA, 32'(i), 32'hfff);
    rd(`GU_OFF_FLAGS, 32'h10, 32'h50);
    // first character stored after the lost one carries overrun
    send_rx(8'hc3, 1'b1);
    rd(`GU_OFF_DATA, 32'h8c3, ALL);
    rd(`GU_OFF_RSR, 32'h8, ALL);
    rd(`GU_OFF_RIS, 32'h400, 32'h400);
    // transmit fifo overfilled while the line drains slowly
    for (int i = 0; i <= DP + 3; i++)
      wr(`GU_OFF_DATA, 4'h1, 32'(i));
    rd(`GU_OFF_FLAGS, 32'h28, 32'ha8);
    repeat ((DP + 3) * 10 * BC) @(posedge core_clk);
    rd(`GU_OFF_FLAGS, 32'h80, 32'ha8);
    rd(`GU_OFF_RIS, 32'h20, 32'h20);
    rd(`GU_OFF_MIS, 32'h0, ALL);
    chk({31'h0, irq}, 32'h0);
    // break character left unread until the receive timeout fires
    send_rx(8'h00, 1'b0);
    repeat (40 * BC) @(posedge core_clk);
    rd(`GU_OFF_RIS, 32'h2c0, 32'h2c0);
    rd(`GU_OFF_DATA, 32'h500, ALL);
    rd(`GU_OFF_RSR, 32'hd, ALL);
    conclude();
  end
endmodule
